// ==== rtl/trsc_pkg.sv ====
// Package with register map, field layout and timing constants of the terminal register block.
package trsc_pkg;

  // ********************************************************************
  // Register indices and field positions
  // ********************************************************************
  localparam logic [5:0]  IDX_TERMINAL_TYPE  = 6'h08;
  localparam logic [5:0]  IDX_FIRMWARE       = 6'h09;
  localparam logic [5:0]  IDX_UNLOCK_CODE    = 6'h1f;
  localparam logic [5:0]  IDX_FEATURE        = 6'h20;
  localparam logic [5:0]  IDX_CLOCK_RATE     = 6'h21;
  localparam logic [5:0]  IDX_POSITION_BITS  = 6'h22;
  localparam logic [5:0]  IDX_FRAME_BITS     = 6'h23;
  localparam logic [5:0]  IDX_USER_FIRST     = 6'h1f;
  localparam logic [5:0]  IDX_USER_LAST      = 6'h2f;

  localparam int          CTL_REG_BIT        = 7;
  localparam int          CTL_WRITE_BIT      = 6;
  localparam int          FEAT_VAR_FRAME_BIT = 6;
  localparam int          FEAT_PFB_BIT       = 5;
  localparam int          FEAT_NO_FRAME_BIT  = 4;

  localparam int          ST_ERROR_BIT       = 6;
  localparam int          ST_PFB_BIT         = 2;
  localparam int          ST_FRAME_BIT       = 1;
  localparam int          ST_LINE_BIT        = 0;

  // ********************************************************************
  // Reset values and codes
  // ********************************************************************
  localparam logic [15:0] UNLOCK_CODE        = 16'h1235;
  localparam logic [15:0] RST_FEATURE        = 16'h0007;
  localparam logic [15:0] RST_CLOCK_RATE     = 16'h0002;
  localparam logic [15:0] RST_POSITION_BITS  = 16'h0018;
  localparam logic [15:0] RST_FRAME_BITS     = 16'h0018;
  localparam logic [7:0]  MAX_BITS           = 8'h20;
  localparam logic [7:0]  MIN_FRAME_BITS     = 8'h02;
  localparam logic [7:0]  RATE_CODE_MIN      = 8'h01;
  localparam logic [7:0]  RATE_CODE_MAX      = 8'h07;

  // ********************************************************************
  // Encoder clock half periods in core cycles at 10 MHz
  // ********************************************************************
  localparam int          CORE_CLK_KHZ       = 10000;
  localparam int          RATE_KHZ_1         = 1000;
  localparam int          RATE_KHZ_2         = 250;
  localparam int          RATE_KHZ_3         = 125;
  localparam int          RATE_KHZ_4         = 100;
  localparam int          RATE_KHZ_5         = 83;
  localparam int          RATE_KHZ_6         = 71;
  localparam int          RATE_HZ_7          = 62500;

  localparam logic [7:0]  HALF_1 = 8'(CORE_CLK_KHZ / (2 * RATE_KHZ_1));
  localparam logic [7:0]  HALF_2 = 8'(CORE_CLK_KHZ / (2 * RATE_KHZ_2));
  localparam logic [7:0]  HALF_3 = 8'(CORE_CLK_KHZ / (2 * RATE_KHZ_3));
  localparam logic [7:0]  HALF_4 = 8'(CORE_CLK_KHZ / (2 * RATE_KHZ_4));
  localparam logic [7:0]  HALF_5 = 8'(CORE_CLK_KHZ / (2 * RATE_KHZ_5));
  localparam logic [7:0]  HALF_6 = 8'(CORE_CLK_KHZ / (2 * RATE_KHZ_6));
  localparam logic [7:0]  HALF_7 = 8'((CORE_CLK_KHZ * 1000) / (2 * RATE_HZ_7));

endpackage

// ==== rtl/trsc_rate_select.sv ====
// Encoder clock rate decoder and divider tick generator.
`timescale 1ns/1ps
module trsc_rate_select
(
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_rate_code,
  output logic            o_half_tick,
  output logic [7:0]      o_half_cycles
);

  logic [7:0] count;
  logic [7:0] half_cycles;

  // Unknown codes fall back to the default rate so the encoder clock never stops.
  always_comb
  begin
    unique case (i_rate_code)
      8'h01:   half_cycles = trsc_pkg::HALF_1;
      8'h03:   half_cycles = trsc_pkg::HALF_3;
      8'h04:   half_cycles = trsc_pkg::HALF_4;
      8'h05:   half_cycles = trsc_pkg::HALF_5;
      8'h06:   half_cycles = trsc_pkg::HALF_6;
      8'h07:   half_cycles = trsc_pkg::HALF_7;
      default: half_cycles = trsc_pkg::HALF_2;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      count         <= 8'h00;
      o_half_tick   <= 1'b0;
      o_half_cycles <= trsc_pkg::HALF_2;
    end
    else
    begin
      o_half_cycles <= half_cycles;
      o_half_tick   <= (count == 8'h00);
      count         <= (count == 8'h00) ? half_cycles - 8'h01 : count - 8'h01;
    end
  end

endmodule // trsc_rate_select

// ==== rtl/trsc_register_bank.sv ====
// Register access and status byte logic of the encoder interface terminal.
// Function
// - Rate code selects encoder clock, high byte ignored
// - Position bit count 0 to 32, default 24
// - Frame length register used only when enabled
// - Frame shorter than data raises frame error
// - Process status byte layout with bit 7 clear
// - General error from frame or line flag
// - Missing stop zero raises frame error
// - Report encoder supply failure bit
// - Control bit 7 selects register access
// - Control bit 6 selects read or write
// - Reads leave contents, value in inbound word
// - Control bits 0 to 5 address 64 registers
// - Status byte first, then two data bytes
// - Read echoes control byte as status
// - Write ack is address with bit 7
// - Outbound word ignored during reads
// - User registers locked until unlock code
// - Register changes act after restart only, except the unlock code, which acts at once
// - Register 9 returns firmware ASCII version
// - Register 8 returns terminal type
// - Code word reads zero while locked
// - Variable frame length limited 2 to 32
`timescale 1ns/1ps
module trsc_register_bank
#(
  parameter logic [15:0] TERMINAL_TYPE = 16'h0001,  // Arbitrary value.
  parameter logic [15:0] FIRMWARE_VER  = 16'h3130   // Arbitrary value.
)
(
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic        i_image_valid,
  input  wire logic [7:0]  i_channel_control_byte,
  input  wire logic [15:0] i_outbound_word,
  input  wire logic [31:0] i_position,
  input  wire logic        i_frame_done,
  input  wire logic        i_stop_bit,
  input  wire logic        i_encoder_supply_fail,
  input  wire logic        i_encoder_line,
  output logic [7:0]       o_channel_status_byte,
  output logic [15:0]      o_inbound_word,
  output logic [31:0]      o_position_data,
  output logic [5:0]       o_position_bits,
  output logic [5:0]       o_frame_bits,
  output logic [7:0]       o_encoder_half_cycles,
  output logic             o_encoder_half_tick,
  output logic             o_unlocked
);

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       line_pin;
  logic       stop_pin;
  logic       supply_pin;

  always_ff @(posedge i_core_clk)
  begin
    sync_a <= {i_encoder_line, i_stop_bit, i_encoder_supply_fail};
    sync_b <= sync_a;
  end

  assign line_pin   = sync_b[2];
  assign stop_pin   = sync_b[1];
  assign supply_pin = sync_b[0];

  // ********************************************************************
  // Register storage
  // ********************************************************************
  // Stored words are written immediately; active copies load only at restart.
  logic [15:0] feature;
  logic [15:0] encoder_clock_rate_select;
  logic [15:0] position_bit_count;
  logic [15:0] frame_bit_count;
  logic [15:0] unlock_code_register;
  logic [15:0] user_mem [int'(trsc_pkg::IDX_USER_FIRST):int'(trsc_pkg::IDX_USER_LAST)];
  logic [15:0] active_feature;
  logic [7:0]  active_rate;
  logic [7:0]  active_data_bits;
  logic [7:0]  active_frame_bits;
  // Power-on state: without a known start value the first reset could not load defaults.
  logic        restarted = 1'b0;

  // ********************************************************************
  // Control byte decode
  // ********************************************************************
  logic        reg_mode;
  logic        write_req;
  logic [5:0]  target_index;
  logic        unlocked;
  logic        is_user;
  logic        write_ok;
  logic [15:0] read_value;
  logic [7:0]  write_ack;

  assign reg_mode     = i_channel_control_byte[trsc_pkg::CTL_REG_BIT];
  assign write_req    = i_channel_control_byte[trsc_pkg::CTL_WRITE_BIT];
  assign target_index = i_channel_control_byte[5:0];
  assign unlocked     = (unlock_code_register == trsc_pkg::UNLOCK_CODE);
  assign is_user      = (target_index >= trsc_pkg::IDX_USER_FIRST)
                     && (target_index <= trsc_pkg::IDX_USER_LAST);
  assign write_ok     = i_image_valid && reg_mode && write_req && is_user
                     && (unlocked || (target_index == trsc_pkg::IDX_UNLOCK_CODE));
  assign write_ack    = {1'b1, 1'b0, target_index};

  function automatic logic [7:0] clamp_bits(input logic [7:0] v, input logic [7:0] lo);
    clamp_bits = (v > trsc_pkg::MAX_BITS) ? trsc_pkg::MAX_BITS : ((v < lo) ? lo : v);
  endfunction

  always_comb
  begin
    unique case (target_index)
      trsc_pkg::IDX_TERMINAL_TYPE: read_value = TERMINAL_TYPE;
      trsc_pkg::IDX_FIRMWARE:      read_value = FIRMWARE_VER;
      trsc_pkg::IDX_UNLOCK_CODE:   read_value = unlocked ? unlock_code_register : 16'h0000;
      trsc_pkg::IDX_FEATURE:       read_value = feature;
      trsc_pkg::IDX_CLOCK_RATE:    read_value = encoder_clock_rate_select;
      trsc_pkg::IDX_POSITION_BITS: read_value = position_bit_count;
      trsc_pkg::IDX_FRAME_BITS:    read_value = frame_bit_count;
      default:                     read_value = is_user ? user_mem[int'(target_index)] : 16'h0000;
    endcase
  end

  // ********************************************************************
  // Register writes
  // ********************************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      unlock_code_register <= 16'h0000;
    end
    else if (i_image_valid && reg_mode && write_req
             && target_index == trsc_pkg::IDX_UNLOCK_CODE)
    begin
      unlock_code_register <= i_outbound_word;
    end
  end

  // User area models retained storage, so reset does not clear it.
  always_ff @(posedge i_core_clk)
  begin
    if (write_ok && !(target_index == trsc_pkg::IDX_UNLOCK_CODE))
    begin
      user_mem[int'(target_index)] <= i_outbound_word;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset && !restarted)
    begin
      feature                   <= trsc_pkg::RST_FEATURE;
      encoder_clock_rate_select <= trsc_pkg::RST_CLOCK_RATE;
      position_bit_count        <= trsc_pkg::RST_POSITION_BITS;
      frame_bit_count           <= trsc_pkg::RST_FRAME_BITS;
    end
    else if (write_ok)
    begin
      unique case (target_index)
        trsc_pkg::IDX_FEATURE:       feature                   <= i_outbound_word;
        trsc_pkg::IDX_CLOCK_RATE:    encoder_clock_rate_select <= i_outbound_word;
        trsc_pkg::IDX_POSITION_BITS: position_bit_count        <= i_outbound_word;
        trsc_pkg::IDX_FRAME_BITS:    frame_bit_count           <= i_outbound_word;
        default:                     feature                   <= feature;
      endcase
    end
  end

  // ********************************************************************
  // Restart-only activation of configuration
  // ********************************************************************
  // The first reset loads defaults; later resets act as the restart that applies writes.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      restarted         <= 1'b1;
      active_feature    <= restarted ? feature : trsc_pkg::RST_FEATURE;
      active_rate       <= restarted ? encoder_clock_rate_select[7:0]
                                     : trsc_pkg::RST_CLOCK_RATE[7:0];
      active_data_bits  <= restarted ? clamp_bits(position_bit_count[7:0], 8'h00)
                                     : trsc_pkg::RST_POSITION_BITS[7:0];
      active_frame_bits <= restarted ? clamp_bits(frame_bit_count[7:0], trsc_pkg::MIN_FRAME_BITS)
                                     : trsc_pkg::RST_FRAME_BITS[7:0];
    end
  end

  trsc_rate_select u_rate_select
  (
    .i_core_clk    (i_core_clk),
    .i_reset       (i_reset),
    .i_rate_code   (active_rate),
    .o_half_tick   (o_encoder_half_tick),
    .o_half_cycles (o_encoder_half_cycles)
  );

  // ********************************************************************
  // Encoder error flags
  // ********************************************************************
  logic       frame_flag;
  logic       line_flag;
  logic       supply_flag;
  logic       var_frame;
  logic       frame_short;
  logic [7:0] frame_len;
  logic       status_error;

  assign var_frame    = active_feature[trsc_pkg::FEAT_VAR_FRAME_BIT];
  assign frame_len    = var_frame ? active_frame_bits : active_data_bits;
  assign frame_short  = var_frame && (active_frame_bits < active_data_bits);
  assign status_error = frame_flag || line_flag;

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      frame_flag  <= 1'b0;
      line_flag   <= 1'b0;
      supply_flag <= 1'b0;
    end
    else
    begin
      line_flag <= !line_pin;
      if (i_frame_done)
      begin
        frame_flag <= frame_short
                   || (stop_pin && !active_feature[trsc_pkg::FEAT_NO_FRAME_BIT]);
        supply_flag <= active_feature[trsc_pkg::FEAT_PFB_BIT] && supply_pin;
      end
    end
  end

  // ********************************************************************
  // Process image answer
  // ********************************************************************
  logic [7:0]  next_status;
  logic [15:0] next_inbound;
  logic [31:0] pos_mask;

  assign pos_mask = (active_data_bits >= trsc_pkg::MAX_BITS) ? 32'hffffffff
                  : ((32'h00000001 << active_data_bits[4:0]) - 32'h00000001);

  always_comb
  begin
    next_status  = {1'b0, status_error, 3'b000, supply_flag, frame_flag, line_flag};
    next_inbound = i_position[15:0];
    if (reg_mode)
    begin
      next_status  = write_req ? write_ack : i_channel_control_byte;
      next_inbound = write_req ? o_inbound_word : read_value;
    end
  end

  // Status, inbound and position outputs hold between images so the coupler always sees the last answer.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_channel_status_byte <= 8'h00;
      o_inbound_word        <= 16'h0000;
      o_position_data       <= 32'h00000000;
      o_position_bits       <= 6'h00;
      o_frame_bits          <= 6'h00;
      o_unlocked            <= 1'b0;
    end
    else
    begin
      o_position_bits <= active_data_bits[5:0];
      o_frame_bits    <= frame_len[5:0];
      o_unlocked      <= unlocked;
      if (i_image_valid)
      begin
        o_channel_status_byte <= next_status;
        o_inbound_word        <= next_inbound;
        o_position_data       <= i_position & pos_mask;
      end
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  sequence s_write_req;
    i_image_valid && reg_mode && write_req;
  endsequence

  chk_read_echo: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_image_valid && reg_mode && !write_req |=> o_channel_status_byte == $past(i_channel_control_byte))
    else $error("read receipt differs from control byte");

  chk_write_ack: assert property (@(posedge i_core_clk) disable iff (i_reset)
    s_write_req |=> o_channel_status_byte == {2'b10, $past(target_index)})
    else $error("write acknowledgement wrong");

  chk_status_bit7: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_image_valid && !reg_mode |=> o_channel_status_byte[7:3] == {1'b0, $past(status_error), 3'b000})
    else $error("process status byte layout wrong");

  chk_error_or: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_image_valid && !reg_mode |=> o_channel_status_byte[trsc_pkg::ST_ERROR_BIT]
    == ($past(frame_flag) || $past(line_flag)))
    else $error("general error mismatch");

  chk_lock_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
    s_write_req ##0 (!unlocked && target_index == trsc_pkg::IDX_CLOCK_RATE)
    |=> $stable(encoder_clock_rate_select))
    else $error("locked register changed");

  chk_code_read: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_image_valid && reg_mode && !write_req && target_index == trsc_pkg::IDX_UNLOCK_CODE
    && !unlocked |=> o_inbound_word == 16'h0000)
    else $error("code word visible while locked");

  chk_read_value: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_image_valid && reg_mode && !write_req |=> o_inbound_word == $past(read_value))
    else $error("read value not returned");

  chk_active_stable: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ##1 $stable(active_rate) && $stable(active_data_bits))
    else $error("configuration changed without restart");

  chk_frame_short: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_frame_done && frame_short |=> frame_flag)
    else $error("short frame not flagged");

endmodule // trsc_register_bank

// ==== testbench/trsc_coupler_model.sv ====
// Behavioural model of the upstream coupler that exchanges the terminal process image.
`timescale 1ns/1ps
module trsc_coupler_model
(
  input  wire logic        i_core_clk,
  input  wire logic [7:0]  i_channel_status_byte,
  input  wire logic [15:0] i_inbound_word,
  output logic             o_image_valid,
  output logic [7:0]       o_channel_control_byte,
  output logic [15:0]      o_outbound_word
);
  // ********************************************************************
  // Image exchange
  // ********************************************************************
  // This coupler places the register word straight after the control byte, with no padding.
  initial
  begin
    o_image_valid          = 1'b0;
    o_channel_control_byte = 8'h00;
    o_outbound_word        = 16'h0000;
  end

  task automatic xfer(input logic [7:0] ctrl, input logic [15:0] word,
                      output logic [7:0] st, output logic [15:0] din);
    @(posedge i_core_clk);
    #1;
    o_image_valid          = 1'b1;
    o_channel_control_byte = ctrl;
    o_outbound_word        = word;
    @(posedge i_core_clk);
    #1;
    // Released lines show the inverse so that a stale capture cannot pass for a good one.
    o_image_valid          = 1'b0;
    o_channel_control_byte = ~ctrl;
    o_outbound_word        = ~word;
    @(posedge i_core_clk);
    #1;
    st  = i_channel_status_byte;
    din = i_inbound_word;
  endtask
endmodule // trsc_coupler_model

// ==== testbench/trsc_register_bank_tb.sv ====
// Self-checking testbench of the terminal register block.
`timescale 1ns/1ps
module trsc_register_bank_tb;
  `define CHK(got, exp, msg) \
    begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
        num_errors++; \
        $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp); \
      end \
    end

  // ********************************************************************
  // Signals and instances
  // ********************************************************************
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic        image_valid;
  logic [7:0]  control_byte;
  logic [15:0] outbound_word;
  logic [31:0] position = 32'h12345678;
  logic        frame_done = 1'b0;
  logic        stop_bit = 1'b0;
  logic        supply_fail = 1'b0;
  logic        encoder_line = 1'b1;
  logic [7:0]  status_byte;
  logic [15:0] inbound_word;
  logic [31:0] position_data;
  logic [5:0]  position_bits;
  logic [5:0]  frame_bits;
  logic [7:0]  half_cycles;
  logic        half_tick;
  logic        unlocked;
  int          num_errors = 0;
  int          check_count = 0;

  always #50 core_clk = ~core_clk;

  trsc_coupler_model trsc_coupler_model_inst
  (
    .i_core_clk             (core_clk),
    .i_channel_status_byte  (status_byte),
    .i_inbound_word         (inbound_word),
    .o_image_valid          (image_valid),
    .o_channel_control_byte (control_byte),
    .o_outbound_word        (outbound_word)
  );

  trsc_register_bank trsc_register_bank_inst
  (
    .i_core_clk             (core_clk),
    .i_reset                (reset),
    .i_image_valid          (image_valid),
    .i_channel_control_byte (control_byte),
    .i_outbound_word        (outbound_word),
    .i_position             (position),
    .i_frame_done           (frame_done),
    .i_stop_bit             (stop_bit),
    .i_encoder_supply_fail  (supply_fail),
    .i_encoder_line         (encoder_line),
    .o_channel_status_byte  (status_byte),
    .o_inbound_word         (inbound_word),
    .o_position_data        (position_data),
    .o_position_bits        (position_bits),
    .o_frame_bits           (frame_bits),
    .o_encoder_half_cycles  (half_cycles),
    .o_encoder_half_tick    (half_tick),
    .o_unlocked             (unlocked)
  );

  // ********************************************************************
  // Access tasks
  // ********************************************************************
  task automatic rd(input logic [5:0] idx, input logic [15:0] exp);
    logic [7:0]  st;
    logic [15:0] din;
    // A changing outbound word proves reads ignore it.
    trsc_coupler_model_inst.xfer({2'b10, idx}, 16'ha5c3 ^ {10'h000, idx}, st, din);
    `CHK(st, {2'b10, idx}, "read receipt")
    `CHK(din, exp, "read value")
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] val);
    logic [7:0]  st;
    logic [15:0] din;
    trsc_coupler_model_inst.xfer({2'b11, idx}, val, st, din);
    `CHK(st, {2'b10, idx}, "write ack")
  endtask

  task automatic proc(input logic [7:0] exp_st);
    logic [7:0]  st;
    logic [15:0] din;
    trsc_coupler_model_inst.xfer(8'h21, 16'h0f0f, st, din);
    `CHK(st, exp_st, "process status")
    `CHK(din, position[15:0], "process word")
  endtask

  task automatic frame(input logic stop, input logic supply);
    stop_bit    = stop;
    supply_fail = supply;
    repeat (4) @(posedge core_clk);
    #1 frame_done = 1'b1;
    @(posedge core_clk);
    #1 frame_done = 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  // Counts core cycles from one divider tick to the next; both waits are bounded.
  task automatic tick_period(input logic [7:0] exp);
    int gap;
    gap = 0;
    while (half_tick !== 1'b1 && gap < 300)
    begin
      @(posedge core_clk);
      #1 gap++;
    end
    gap = 0;
    do
    begin
      @(posedge core_clk);
      #1 gap++;
    end
    while (half_tick !== 1'b1 && gap < 300);
    `CHK(gap, int'(exp), "tick period")
  endtask

  task automatic do_reset(input int cycles);
    @(posedge core_clk);
    #1 reset = 1'b1;
    repeat (cycles) @(posedge core_clk);
    #1 reset = 1'b0;
    // Outputs pick up the restarted configuration at the first edge out of reset.
    @(posedge core_clk);
    #1;
  endtask

  task automatic results;
    $display("Checks made: %0d, mismatches: %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial
  begin
    repeat (6) @(posedge core_clk);
    #1 reset = 1'b0;
    proc(8'h00);
    `CHK(position_data, 32'h00345678, "default length")
    `CHK(half_cycles, trsc_pkg::HALF_2, "default rate")
    `CHK(frame_bits, 6'd24, "frame follows data length")
    tick_period(trsc_pkg::HALF_2);
    rd(trsc_pkg::IDX_CLOCK_RATE, 16'h0002);
    rd(trsc_pkg::IDX_POSITION_BITS, 16'h0018);
    rd(trsc_pkg::IDX_TERMINAL_TYPE, 16'h0001);
    rd(trsc_pkg::IDX_FIRMWARE, 16'h3130);
    rd(trsc_pkg::IDX_UNLOCK_CODE, 16'h0000);
    rd(6'h3e, 16'h0000);
    wr(trsc_pkg::IDX_CLOCK_RATE, 16'h0001);
    rd(trsc_pkg::IDX_CLOCK_RATE, 16'h0002);
    wr(trsc_pkg::IDX_UNLOCK_CODE, trsc_pkg::UNLOCK_CODE);
    rd(trsc_pkg::IDX_UNLOCK_CODE, 16'h1235);
    rd(trsc_pkg::IDX_UNLOCK_CODE, 16'h1235);
    `CHK(unlocked, 1'b1, "unlocked")
    wr(trsc_pkg::IDX_FEATURE, 16'h0067);
    wr(trsc_pkg::IDX_CLOCK_RATE, 16'hff05);
    wr(trsc_pkg::IDX_POSITION_BITS, 16'h0010);
    wr(trsc_pkg::IDX_FRAME_BITS, 16'h0008);
    rd(trsc_pkg::IDX_POSITION_BITS, 16'h0010);
    `CHK(half_cycles, trsc_pkg::HALF_2, "rate before restart")
    `CHK(position_bits, 6'd24, "length before restart")
    encoder_line = 1'b0;
    repeat (5) @(posedge core_clk);
    proc(8'h41);
    encoder_line = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    // The supply flag stays hidden until the feature bit becomes active.
    frame(1'b1, 1'b1);
    proc(8'h42);
    frame(1'b0, 1'b0);
    proc(8'h00);
    do_reset(2);
    `CHK(half_cycles, trsc_pkg::HALF_5, "rate after restart")
    tick_period(trsc_pkg::HALF_5);
    `CHK(position_bits, 6'd16, "length after restart")
    `CHK(frame_bits, 6'd8, "frame after restart")
    `CHK(unlocked, 1'b0, "relocked by restart")
    rd(trsc_pkg::IDX_UNLOCK_CODE, 16'h0000);
    frame(1'b0, 1'b1);
    proc(8'h46);
    `CHK(position_data, 32'h00005678, "short length")
    wr(trsc_pkg::IDX_UNLOCK_CODE, trsc_pkg::UNLOCK_CODE);
    wr(trsc_pkg::IDX_UNLOCK_CODE, 16'h1234);
    rd(trsc_pkg::IDX_UNLOCK_CODE, 16'h0000);
    `CHK(unlocked, 1'b0, "other value relocks")
    wr(trsc_pkg::IDX_CLOCK_RATE, 16'h0003);
    rd(trsc_pkg::IDX_CLOCK_RATE, 16'hff05);
    results();
  end
endmodule // trsc_register_bank_tb
